// ==== common/node_cfg_pkg.sv ====
/*
 * package for the fieldbus node configuration and diagnosis block:
 * parameter addresses, reset values, diagnosis bit positions, value limits.
 * assumes the parameter port carries 16-bit values at the printed addresses.
 */
package node_cfg_pkg;
    localparam int          PAR_AW            = 16;
    localparam int          PAR_DW            = 16;
    localparam int          DIAG_BITS         = 12;
    localparam int          PDO4_OBJS         = 4;

    localparam logic [15:0] ADDR_NODE_ADDRESS = 16'h1704;
    localparam logic [15:0] ADDR_BIT_RATE     = 16'h1706;
    localparam logic [15:0] ADDR_PDO4_MASK    = 16'h170a;
    localparam logic [15:0] ADDR_DIAG_WORD    = 16'h170c;

    localparam logic [15:0] NODE_ADDRESS_MIN  = 16'h0001;
    localparam logic [15:0] NODE_ADDRESS_MAX  = 16'h007f;
    localparam logic [15:0] NODE_ADDRESS_RST  = 16'h007f;
    localparam logic [15:0] BIT_RATE_RST      = 16'h007d;
    localparam logic [15:0] PDO4_MASK_RST     = 16'h000f;
    localparam logic [15:0] PDO4_MASK_MAX     = 16'h000f;
    localparam logic [15:0] ZERO_WORD         = 16'h0000;

    // accepted bit rates in kbaud
    localparam logic [15:0] RATE_50K          = 16'h0032;
    localparam logic [15:0] RATE_125K         = 16'h007d;
    localparam logic [15:0] RATE_250K         = 16'h00fa;
    localparam logic [15:0] RATE_500K         = 16'h01f4;
    localparam logic [15:0] RATE_1000K        = 16'h03e8;

    // diagnosis word bit positions
    localparam int          DIAG_TXPDO_RD     = 0;
    localparam int          DIAG_RXPDO1_WR    = 1;
    localparam int          DIAG_RXPDO2_WR    = 2;
    localparam int          DIAG_RXPDO3_WR    = 3;
    localparam int          DIAG_RXPDO4_WR    = 4;
    localparam int          DIAG_GUARD_TIMER  = 5;
    localparam int          DIAG_HB_STATE     = 6;
    localparam int          DIAG_BUS_WARN     = 7;
    localparam int          DIAG_MSG_LOST     = 8;
    localparam int          DIAG_BUS_OFF      = 9;
    localparam int          DIAG_QUEUE_OVR    = 10;
    localparam int          DIAG_STOP_FAULT   = 11;
endpackage

// ==== verif/canopen_node_config_diag_tb.sv ====
/*
 * self-checking bench for the node configuration and diagnosis block.
 * assumes the parameter master model drives the parameter port.
 */
`timescale 1ns/1ps
`default_nettype none
module canopen_node_config_diag_tb
    import node_cfg_pkg::*;
;
    logic        core_clk = 1'b0, rst_b = 1'b0, nv_valid = 1'b0, nmt_reset_cmd = 1'b0;
    logic [15:0] nv_node_address = 16'h0, nv_bit_rate = 16'h0, par_addr, par_wdata;
    logic [15:0] par_rdata, node_address_setting, bit_rate_setting, q, v, r;
    logic [15:0] fourth_pdo_event_mask, active_node_address, active_bit_rate;
    logic        par_wr, par_rd, par_ack, par_err, pdo4_event_tx, k, e;
    logic [11:0] diag_event = 12'h0;
    logic [3:0]  pdo4_obj_changed = 4'h0, m;
    int          n_mismatch = 0, samples_checked = 0, cycles = 0;
    logic [15:0] na [5] = '{16'h0000, 16'h0080, 16'h0001, 16'h007f, 16'hffff};
    logic [15:0] rt [7] = '{RATE_125K, RATE_50K, RATE_500K, RATE_1000K, RATE_250K,
                            16'h0064, 16'h0000};

    always #5 core_clk = ~core_clk;

    node_cfg_diag u_dut (.core_clk, .rst_b, .par_addr, .par_wr, .par_rd, .par_wdata,
        .par_rdata, .par_ack, .par_err, .nv_valid, .nv_node_address, .nv_bit_rate,
        .nmt_reset_cmd, .diag_event, .pdo4_obj_changed, .node_address_setting,
        .bit_rate_setting, .fourth_pdo_event_mask, .active_node_address,
        .active_bit_rate, .pdo4_event_tx);
    par_master_model u_master (.core_clk, .par_addr, .par_wr, .par_rd, .par_wdata,
        .par_rdata, .par_ack, .par_err);

    function automatic logic addr_ok(input logic [15:0] x);
        return x >= NODE_ADDRESS_MIN && x <= NODE_ADDRESS_MAX;
    endfunction
    function automatic logic rate_ok(input logic [15:0] x);
        return x inside {RATE_50K, RATE_125K, RATE_250K, RATE_500K, RATE_1000K};
    endfunction
    task automatic check(input logic [15:0] s, x);
        samples_checked++;
        if (s !== x) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    // one access; ack must answer and error must match the expectation
    task automatic acc(input logic w, input logic [15:0] a, d, input logic xe);
        u_master.access(w, a, d, q, k, e);
        check({14'h0, k, e}, {14'h0, 1'b1, xe});
    endtask
    task automatic do_reset;
        @(posedge core_clk);
        #1 rst_b = 1'b0;
        repeat (3) @(posedge core_clk);
        #1 rst_b = 1'b1;
        @(posedge core_clk);
        #1;
    endtask
    task automatic pulse_nmt;
        @(posedge core_clk);
        #1 nmt_reset_cmd = 1'b1;
        @(posedge core_clk);
        #1 nmt_reset_cmd = 1'b0;
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            conclude;
        end
    end

    initial begin
        void'($urandom(32'h601351bf));
        do_reset;
        check(active_node_address, NODE_ADDRESS_RST);
        check(active_bit_rate, BIT_RATE_RST);
        acc(0, ADDR_NODE_ADDRESS, 0, 0);
        check(q, NODE_ADDRESS_RST);
        acc(0, ADDR_BIT_RATE, 0, 0);
        check(q, BIT_RATE_RST);
        acc(0, ADDR_PDO4_MASK, 0, 0);
        check(q, PDO4_MASK_RST);
        acc(0, ADDR_DIAG_WORD, 0, 0);
        check(q, ZERO_WORD);
        acc(0, 16'h1708, 0, 1);
        $display("test reset values done");
        r = BIT_RATE_RST;
        for (int i = 0; i < 10; i++) begin
            v = i < 7 ? rt[i] : 16'($urandom_range(1100));
            acc(1, ADDR_BIT_RATE, v, !rate_ok(v));
            if (rate_ok(v)) r = v;
            check(bit_rate_setting, r);
            check(active_bit_rate, BIT_RATE_RST);
        end
        acc(0, ADDR_BIT_RATE, 0, 0);
        check(q, r);
        r = NODE_ADDRESS_RST;
        for (int i = 0; i < 9; i++) begin
            v = i < 5 ? na[i] : 16'($urandom_range(200));
            acc(1, ADDR_NODE_ADDRESS, v, !addr_ok(v));
            if (addr_ok(v)) r = v;
            check(node_address_setting, r);
            check(active_node_address, NODE_ADDRESS_RST);
        end
        pulse_nmt;
        check(active_node_address, r);
        check(active_bit_rate, BIT_RATE_RST);
        $display("test settings done");
        for (int i = 0; i <= DIAG_BITS; i++) begin
            v = i < DIAG_BITS ? 16'h1 << i : 16'($urandom_range(16'h0fff));
            @(posedge core_clk);
            #1 diag_event = v[11:0];
            @(posedge core_clk);
            #1 diag_event = 12'h0;
            acc(0, ADDR_DIAG_WORD, 0, 0);
            check(q, v);
            acc(0, ADDR_DIAG_WORD, 0, 0);
            check(q, ZERO_WORD);
        end
        acc(1, ADDR_DIAG_WORD, 16'h0fff, 1);
        // bus-off event held through the clearing read: the set must survive
        diag_event = 12'h200;
        acc(0, ADDR_DIAG_WORD, 0, 0);
        check(q, 16'h0200);
        diag_event = 12'h0;
        acc(0, ADDR_DIAG_WORD, 0, 0);
        check(q, 16'h0200);
        acc(0, ADDR_DIAG_WORD, 0, 0);
        check(q, ZERO_WORD);
        $display("test diagnosis done");
        r = PDO4_MASK_RST;
        for (int i = 0; i < 14; i++) begin
            v = i == 0 ? 16'h0010 : (i == 1 ? 16'h0000 : 16'($urandom_range(20)));
            acc(1, ADDR_PDO4_MASK, v, v > PDO4_MASK_MAX);
            if (v <= PDO4_MASK_MAX) r = v;
            check(fourth_pdo_event_mask, r);
            @(posedge core_clk);
            #1 pdo4_obj_changed = 4'($urandom);
            m = pdo4_obj_changed;
            @(posedge core_clk);
            #1 pdo4_obj_changed = 4'h0;
            check({15'h0, pdo4_event_tx}, {15'h0, |(m & r[3:0])});
        end
        $display("test event mask done");
        nv_valid = 1'b1;
        nv_node_address = 16'h0000;
        nv_bit_rate = RATE_250K;
        do_reset;
        check(active_bit_rate, RATE_250K);
        check(active_node_address, NODE_ADDRESS_RST);
        nv_node_address = 16'h0005;
        nv_bit_rate = 16'h0064;
        do_reset;
        check(active_node_address, 16'h0005);
        check(bit_rate_setting, BIT_RATE_RST);
        $display("test persistent load done");
        conclude;
    end
endmodule
`default_nettype wire

// ==== verif/par_master_model.sv ====
/*
 * far-side parameter master: one task issues a read or write on the
 * parameter port and returns ack, error flag and read data.
 * assumes the answer comes exactly one cycle after the request edge.
 */
`timescale 1ns/1ps
`default_nettype none
module par_master_model
    import node_cfg_pkg::*;
(
    input  wire logic              core_clk,
    output var  logic [PAR_AW-1:0] par_addr,
    output var  logic              par_wr,
    output var  logic              par_rd,
    output var  logic [PAR_DW-1:0] par_wdata,
    input  wire logic [PAR_DW-1:0] par_rdata,
    input  wire logic              par_ack,
    input  wire logic              par_err
);
    initial begin
        par_addr  = '0;
        par_wr    = 1'b0;
        par_rd    = 1'b0;
        par_wdata = '0;
    end
    task automatic access(input logic w, input logic [15:0] a, d,
                          output logic [15:0] q, output logic k, e);
        @(posedge core_clk);
        #1;
        par_wr    = w;
        par_rd    = !w;
        par_addr  = a;
        par_wdata = w ? d : ~d;
        @(posedge core_clk);
        #1;
        q         = par_rdata;
        k         = par_ack;
        e         = par_err;
        par_wr    = 1'b0;
        par_rd    = 1'b0;
        // released lines must not keep showing the request
        par_addr  = ~a;
        par_wdata = ~par_wdata;
    endtask
endmodule
`default_nettype wire

// ==== verilog/node_cfg_diag.sv ====
/*
 * fieldbus node configuration and diagnosis: node address, bit rate,
 * fourth pdo event mask, sticky diagnosis word behind a parameter port.
 * assumes nonvolatile contents arrive on nv_* and are valid at reset release,
 * and that event inputs come from logic on core_clk.
 */
// Operation
// - node address accepts 1 to 127, starts at 127 and is kept for the persistent store.
// - a new node address becomes active only at power-up or on a network reset command.
// - bit rate accepts 50, 125, 250, 500 or 1000 kbaud, starts at 125 and is kept.
// - a new bit rate becomes active only at the next power-up.
// - diagnosis 0x0001 flags a tx pdo read failure, 0x0002..0x0010 rx pdo 1..4 write failures.
// - diagnosis flags 0x0020 on guard timer expiry and 0x0040 on a heartbeat with wrong state.
// - diagnosis flags 0x0080 bus warning, 0x0100 message lost and 0x0200 bus-off.
// - diagnosis flags 0x0400 queue overrun and 0x0800 stop fault indication.
// - mask bits 0..3 enable sending on change of mapped objects 1..4, rest reserved, max 15.
`timescale 1ns/1ps
`default_nettype none
module node_cfg_diag
    import node_cfg_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 rst_b,
    input  wire logic [PAR_AW-1:0]    par_addr,
    input  wire logic                 par_wr,
    input  wire logic                 par_rd,
    input  wire logic [PAR_DW-1:0]    par_wdata,
    output var  logic [PAR_DW-1:0]    par_rdata,
    output var  logic                 par_ack,
    output var  logic                 par_err,
    input  wire logic                 nv_valid,
    input  wire logic [PAR_DW-1:0]    nv_node_address,
    input  wire logic [PAR_DW-1:0]    nv_bit_rate,
    input  wire logic                 nmt_reset_cmd,
    input  wire logic [DIAG_BITS-1:0] diag_event,
    input  wire logic [PDO4_OBJS-1:0] pdo4_obj_changed,
    output var  logic [PAR_DW-1:0]    node_address_setting,
    output var  logic [PAR_DW-1:0]    bit_rate_setting,
    output var  logic [PAR_DW-1:0]    fourth_pdo_event_mask,
    output var  logic [PAR_DW-1:0]    active_node_address,
    output var  logic [PAR_DW-1:0]    active_bit_rate,
    output var  logic                 pdo4_event_tx
);
    logic                 load_done;
    logic [DIAG_BITS-1:0] diag_q;
    logic [DIAG_BITS-1:0] diag_clr;
    logic                 sel_addr;
    logic                 sel_rate;
    logic                 sel_mask;
    logic                 sel_diag;
    logic                 addr_ok;
    logic                 rate_ok;
    logic                 mask_ok;
    logic                 wr_addr;
    logic                 wr_rate;
    logic                 wr_mask;
    logic [PAR_DW-1:0]    boot_addr;
    logic [PAR_DW-1:0]    boot_rate;
    logic [PAR_DW-1:0]    link_diagnosis_word;

    function automatic logic rate_valid(input logic [PAR_DW-1:0] v);
        return (v == RATE_50K) || (v == RATE_125K) || (v == RATE_250K) ||
               (v == RATE_500K) || (v == RATE_1000K);
    endfunction

    assign sel_addr = (par_addr == ADDR_NODE_ADDRESS);
    assign sel_rate = (par_addr == ADDR_BIT_RATE);
    assign sel_mask = (par_addr == ADDR_PDO4_MASK);
    assign sel_diag = (par_addr == ADDR_DIAG_WORD);

    assign addr_ok  = (par_wdata >= NODE_ADDRESS_MIN) &&
                      (par_wdata <= NODE_ADDRESS_MAX);
    assign rate_ok  = rate_valid(par_wdata);
    assign mask_ok  = (par_wdata <= PDO4_MASK_MAX);

    // refused values never reach the setting
    assign wr_addr  = load_done && par_wr && sel_addr && addr_ok;
    assign wr_rate  = load_done && par_wr && sel_rate && rate_ok;
    assign wr_mask  = load_done && par_wr && sel_mask && mask_ok;

    // persistent contents are taken only if they are themselves legal
    assign boot_addr = (nv_valid && nv_node_address >= NODE_ADDRESS_MIN &&
                        nv_node_address <= NODE_ADDRESS_MAX) ? nv_node_address
                                                             : NODE_ADDRESS_RST;
    assign boot_rate = (nv_valid && rate_valid(nv_bit_rate)) ? nv_bit_rate : BIT_RATE_RST;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            load_done <= 1'b0;
        end else begin
            load_done <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            node_address_setting <= NODE_ADDRESS_RST;
        end else if (!load_done) begin
            node_address_setting <= boot_addr;
        end else if (wr_addr) begin
            node_address_setting <= par_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bit_rate_setting <= BIT_RATE_RST;
        end else if (!load_done) begin
            bit_rate_setting <= boot_rate;
        end else if (wr_rate) begin
            bit_rate_setting <= par_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            fourth_pdo_event_mask <= PDO4_MASK_RST;
        end else if (wr_mask) begin
            fourth_pdo_event_mask <= par_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            active_node_address <= NODE_ADDRESS_RST;
        end else if (!load_done) begin
            active_node_address <= boot_addr;
        end else if (nmt_reset_cmd) begin
            active_node_address <= node_address_setting;
        end
    end

    // no run-time path: only the power-up load moves the active rate
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            active_bit_rate <= BIT_RATE_RST;
        end else if (!load_done) begin
            active_bit_rate <= boot_rate;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pdo4_event_tx <= 1'b0;
        end else begin
            pdo4_event_tx <= |(pdo4_obj_changed & fourth_pdo_event_mask[PDO4_OBJS-1:0]);
        end
    end

    // diagnosis bits clear when the word is read
    assign diag_clr = (par_rd && sel_diag) ? {DIAG_BITS{1'b1}} : '0;

    sticky_flag #(
        .W (DIAG_BITS)
    ) diag_flags (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .set      (diag_event),
        .clr      (diag_clr),
        .q        (diag_q)
    );

    assign link_diagnosis_word = {{(PAR_DW-DIAG_BITS){1'b0}}, diag_q};

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            par_rdata <= ZERO_WORD;
            par_ack   <= 1'b0;
            par_err   <= 1'b0;
        end else begin
            par_ack   <= par_rd || par_wr;
            par_err   <= 1'b0;
            par_rdata <= ZERO_WORD;
            if (par_rd) begin
                unique case (1'b1)
                    sel_addr: par_rdata <= node_address_setting;
                    sel_rate: par_rdata <= bit_rate_setting;
                    sel_mask: par_rdata <= fourth_pdo_event_mask;
                    sel_diag: par_rdata <= link_diagnosis_word;
                    default:  par_err   <= 1'b1;
                endcase
            end else if (par_wr) begin
                par_err <= !(wr_addr || wr_rate || wr_mask);
            end
        end
    end

    a_addr_range: assert property (@(posedge core_clk) disable iff (!rst_b)
        node_address_setting >= NODE_ADDRESS_MIN && node_address_setting <= NODE_ADDRESS_MAX)
        else $error("node address out of range");

    a_rate_legal: assert property (@(posedge core_clk) disable iff (!rst_b)
        rate_valid(bit_rate_setting) && rate_valid(active_bit_rate))
        else $error("bit rate not an accepted value");

    a_bad_refused: assert property (@(posedge core_clk) disable iff (!rst_b)
        load_done && par_wr && ((sel_addr && !addr_ok) || (sel_rate && !rate_ok))
        |=> $stable(node_address_setting) && $stable(bit_rate_setting) && par_err)
        else $error("illegal value was stored");

    a_good_stored: assert property (@(posedge core_clk) disable iff (!rst_b)
        load_done && par_wr && sel_addr && addr_ok
        |=> node_address_setting == $past(par_wdata) && par_ack && !par_err)
        else $error("legal node address not stored");

    a_addr_deferred: assert property (@(posedge core_clk) disable iff (!rst_b)
        load_done && !nmt_reset_cmd |=> $stable(active_node_address))
        else $error("node address activated without reset command");

    a_nmt_applies: assert property (@(posedge core_clk) disable iff (!rst_b)
        load_done && nmt_reset_cmd |=> active_node_address == $past(node_address_setting))
        else $error("reset command did not apply node address");

    a_rate_frozen: assert property (@(posedge core_clk) disable iff (!rst_b)
        load_done |=> $stable(active_bit_rate))
        else $error("bit rate changed after power-up");

    a_diag_sticky: assert property (@(posedge core_clk) disable iff (!rst_b)
        diag_event != '0 |=> (diag_q & $past(diag_event)) == $past(diag_event))
        else $error("diagnosis event lost");

    a_diag_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
        !(par_rd && sel_diag) && diag_event == '0 |=> $stable(diag_q))
        else $error("diagnosis bit changed without cause");

    a_mask_event: assert property (@(posedge core_clk) disable iff (!rst_b)
        ##1 pdo4_event_tx ==
        |($past(pdo4_obj_changed) & $past(fourth_pdo_event_mask[PDO4_OBJS-1:0])))
        else $error("pdo4 event does not follow mask");

    a_mask_range: assert property (@(posedge core_clk) disable iff (!rst_b)
        fourth_pdo_event_mask <= PDO4_MASK_MAX)
        else $error("pdo4 mask out of range");

    c_nmt_new_addr: cover property (@(posedge core_clk) disable iff (!rst_b)
        wr_addr ##[1:20] (nmt_reset_cmd && active_node_address != node_address_setting));
    c_rate_write: cover property (@(posedge core_clk) disable iff (!rst_b) wr_rate);
    c_diag_clear: cover property (@(posedge core_clk) disable iff (!rst_b)
        diag_q != '0 ##1 (par_rd && sel_diag));
    c_pdo4_tx: cover property (@(posedge core_clk) disable iff (!rst_b) pdo4_event_tx);
endmodule
`default_nettype wire

// ==== verilog/sticky_flag.sv ====
/*
 * sticky flag bank: each bit is set by its event and cleared by a clear strobe.
 * assumes set and clear come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module sticky_flag #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output var  logic [W-1:0] q
);
    // a set in the clearing cycle survives
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= set | (q & ~clr);
        end
    end
endmodule
`default_nettype wire
